/* File: include/adh_pkg.sv */
// adh_pkg: constants for the parallel disk host port
// assumes a 200 MHz core clock; no software registers
package adh_pkg;
  localparam int          CLK_MHZ          = 200;
  localparam int          STROBE_NS        = 70;
  localparam int          SETUP_NS         = 25;
  localparam int          HOLD_NS          = 10;
  localparam int          RESET_US         = 25;
  localparam logic [7:0]  STROBE_CYC       = 8'((STROBE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0]  SETUP_CYC        = 8'((SETUP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0]  HOLD_CYC         = 8'((HOLD_NS * CLK_MHZ + 999) / 1000);
  localparam int          RESET_CYC_DEF    = (RESET_US * CLK_MHZ);
  localparam logic [9:0]  CMD_BASE         = 10'h1F0;
  localparam logic [9:0]  CTRL_BASE        = 10'h3F0;
  localparam logic [9:0]  RANGE_MASK       = 10'h3F0;
  localparam logic [2:0]  MODE_UDMA66      = 3'h4;
  localparam logic [15:0] DATA_RESET       = 16'h0000;

  typedef enum logic [2:0] {
    ADH_IDLE   = 3'b000,
    ADH_SETUP  = 3'b001,
    ADH_STROBE = 3'b011,
    ADH_WAIT   = 3'b010,
    ADH_HOLD   = 3'b110
  } adh_state_e;
endpackage

/* File: src/adh_decode.sv */
// adh_decode: maps a 10-bit i/o address onto the two chip select ranges
// assumes a stable address from the caller
`timescale 1ns/1ps
`default_nettype none
module adh_decode
  import adh_pkg::*;
(
  // address in
  input  wire logic [9:0] io_addr,
  // range hits
  output logic            hit_cmd,
  output logic            hit_ctrl
);
  assign hit_cmd  = (io_addr & RANGE_MASK) == CMD_BASE;
  assign hit_ctrl = (io_addr & RANGE_MASK) == CTRL_BASE;
endmodule
`default_nettype wire

/* File: src/adh_host_port.sv */
// adh_host_port: host end of a parallel disk interface with pio and dma cycles
// assumes synchronous pins and a system side that holds req until ack
`timescale 1ns/1ps
`default_nettype none
module adh_host_port
  import adh_pkg::*;
#(
  parameter int RESET_CYC = RESET_CYC_DEF
)(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // system request side
  input  wire logic        sys_req,
  input  wire logic        sys_write,
  input  wire logic        sys_dma,
  input  wire logic [9:0]  sys_addr,
  input  wire logic [15:0] sys_wdata,
  input  wire logic        sys_drive_reset,
  input  wire logic [2:0]  sys_mode,
  output logic             sys_ack,
  output logic [15:0]      sys_rdata,
  output logic             sys_irq_event,
  output logic             sys_cable_80,
  output logic             sys_udma_fast_ok,
  output logic             sys_dma_pending,
  output logic             sys_reset_busy,
  // drive side
  input  wire logic [15:0] drive_data_in,
  output logic [15:0]      drive_data_out,
  output logic             drive_data_oe,
  output logic [2:0]       drive_reg_addr,
  output logic             drive_write_strobe_n,
  output logic             drive_read_strobe_n,
  input  wire logic        drive_dma_request,
  output logic             drive_dma_ack_n,
  output logic             cmd_block_select_n,
  output logic             ctrl_block_select_n,
  input  wire logic        drive_ready_wait,
  output logic             drive_reset_n,
  input  wire logic        drive_interrupt,
  input  wire logic        cable_type_detect_n
);

  ////////////////////////////////////////////////////////////////////////////
  adh_state_e  state;
  logic [7:0]  cnt;
  logic        cur_write;
  logic        cur_dma;
  logic        hit_cmd;
  logic        hit_ctrl;
  logic        irq_q;
  logic [31:0] rst_cnt;
  logic        start;

  adh_decode u_dec (
    .io_addr  (sys_addr),
    .hit_cmd  (hit_cmd),
    .hit_ctrl (hit_ctrl)
  );

  function automatic logic fast_mode(input logic [2:0] m);
    return m >= MODE_UDMA66;
  endfunction

  assign start = sys_req && !sys_ack && !sys_reset_busy && !sys_drive_reset && state == ADH_IDLE
                 && (!sys_dma || drive_dma_request);

  ////////////////////////////////////////////////////////////////////////////
  // cycle sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ADH_IDLE;
      cnt   <= 8'h00;
    end else begin
      case (state)
        ADH_IDLE: begin
          if (start) begin
            state <= ADH_SETUP;
            cnt   <= SETUP_CYC;
          end
        end
        ADH_SETUP: begin
          if (cnt <= 8'h01) begin
            state <= ADH_STROBE;
            cnt   <= STROBE_CYC;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        ADH_STROBE: begin
          if (cnt <= 8'h01) begin
            state <= ADH_WAIT;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        ADH_WAIT: begin
          if (drive_ready_wait) begin
            state <= ADH_HOLD;
            cnt   <= HOLD_CYC;
          end
        end
        ADH_HOLD: begin
          if (cnt <= 8'h01) begin
            state <= ADH_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        default: begin
          state <= ADH_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle latches, address, selects, acknowledge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cur_write           <= 1'b0;
      cur_dma             <= 1'b0;
      drive_reg_addr      <= 3'h0;
      cmd_block_select_n  <= 1'b1;
      ctrl_block_select_n <= 1'b1;
      drive_dma_ack_n     <= 1'b1;
      drive_data_out      <= DATA_RESET;
      drive_data_oe       <= 1'b0;
    end else if (start) begin
      cur_write           <= sys_write;
      cur_dma             <= sys_dma;
      drive_reg_addr      <= sys_dma ? 3'h0 : sys_addr[2:0];
      cmd_block_select_n  <= !(hit_cmd && !sys_dma);
      ctrl_block_select_n <= !(hit_ctrl && !sys_dma);
      drive_dma_ack_n     <= !sys_dma;
      drive_data_out      <= sys_wdata;
      drive_data_oe       <= sys_write;
    end else if (state == ADH_HOLD && cnt <= 8'h01) begin
      cmd_block_select_n  <= 1'b1;
      ctrl_block_select_n <= 1'b1;
      drive_dma_ack_n     <= 1'b1;
      drive_data_oe       <= 1'b0; // data held through hold time
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobes: low through strobe and ready-wait phases
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      drive_write_strobe_n <= 1'b1;
      drive_read_strobe_n  <= 1'b1;
    end else if (state == ADH_SETUP && cnt <= 8'h01) begin
      drive_write_strobe_n <= !cur_write;
      drive_read_strobe_n  <= cur_write;
    end else if (state == ADH_WAIT && drive_ready_wait) begin
      drive_write_strobe_n <= 1'b1;
      drive_read_strobe_n  <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read capture and completion
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sys_rdata <= DATA_RESET;
      sys_ack   <= 1'b0;
    end else begin
      if (state == ADH_WAIT && drive_ready_wait && !cur_write)
        sys_rdata <= drive_data_in;
      sys_ack <= state == ADH_HOLD && cnt <= 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_cnt        <= 32'(RESET_CYC);
      drive_reset_n  <= 1'b0;
      sys_reset_busy <= 1'b1;
    end else if (sys_drive_reset && state == ADH_IDLE) begin
      rst_cnt        <= 32'(RESET_CYC);
      drive_reset_n  <= 1'b0;
      sys_reset_busy <= 1'b1;
    end else if (rst_cnt > 32'h1) begin
      rst_cnt <= rst_cnt - 32'h1;
    end else begin
      drive_reset_n  <= 1'b1;
      sys_reset_busy <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt event, cable type, dma status
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_q            <= 1'b1;
      sys_irq_event    <= 1'b0;
      sys_cable_80     <= 1'b0;
      sys_udma_fast_ok <= 1'b0;
      sys_dma_pending  <= 1'b0;
    end else begin
      irq_q            <= drive_interrupt;
      sys_irq_event    <= drive_interrupt && !irq_q;
      sys_cable_80     <= !cable_type_detect_n;
      sys_udma_fast_ok <= !cable_type_detect_n || !fast_mode(sys_mode);
      sys_dma_pending  <= drive_dma_request;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_strobe_low;
    !drive_write_strobe_n || !drive_read_strobe_n;
  endsequence
  property p_dma_no_cs;
    @(posedge clk) disable iff (!rstn)
      !drive_dma_ack_n |-> cmd_block_select_n && ctrl_block_select_n;
  endproperty
  a_dma_no_cs: assert property (p_dma_no_cs) else $error("chip select during dma");
  property p_strobe_has_sel;
    @(posedge clk) disable iff (!rstn)
      s_strobe_low |-> (drive_dma_ack_n == !cur_dma);
  endproperty
  a_strobe_has_sel: assert property (p_strobe_has_sel) else $error("strobe acknowledge mismatch");
  property p_wait_holds;
    @(posedge clk) disable iff (!rstn)
      (state == ADH_WAIT && !drive_ready_wait) |=> s_strobe_low;
  endproperty
  a_wait_holds: assert property (p_wait_holds) else $error("strobe released while not ready");
  property p_wdata_stable;
    @(posedge clk) disable iff (!rstn)
      $rose(drive_write_strobe_n) |-> drive_data_oe && $stable(drive_data_out);
  endproperty
  a_wdata_stable: assert property (p_wdata_stable) else $error("write data moved at strobe rise");
  property p_read_no_drive;
    @(posedge clk) disable iff (!rstn)
      !drive_read_strobe_n |-> !drive_data_oe;
  endproperty
  a_read_no_drive: assert property (p_read_no_drive) else $error("bus driven during read");
  property p_irq_event;
    @(posedge clk) disable iff (!rstn)
      $rose(drive_interrupt) |=> sys_irq_event;
  endproperty
  a_irq_event: assert property (p_irq_event) else $error("interrupt edge not forwarded");
  property p_fast_cable;
    @(posedge clk) disable iff (!rstn)
      (cable_type_detect_n && fast_mode(sys_mode)) |=> !sys_udma_fast_ok;
  endproperty
  a_fast_cable: assert property (p_fast_cable) else $error("fast udma on 40-conductor cable");
  property p_cable;
    @(posedge clk) disable iff (!rstn)
      1'b1 |=> sys_cable_80 == !$past(cable_type_detect_n);
  endproperty
  a_cable: assert property (p_cable) else $error("cable type wrong");
  property p_cs_range;
    @(posedge clk) disable iff (!rstn)
      start && !hit_cmd |=> cmd_block_select_n;
  endproperty
  a_cs_range: assert property (p_cs_range) else $error("command select out of range");
  property p_cs3_range;
    @(posedge clk) disable iff (!rstn)
      start && !hit_ctrl |=> ctrl_block_select_n;
  endproperty
  a_cs3_range: assert property (p_cs3_range) else $error("control select out of range");
  property p_dma_ack;
    @(posedge clk) disable iff (!rstn)
      start && sys_dma |=> !drive_dma_ack_n;
  endproperty
  a_dma_ack: assert property (p_dma_ack) else $error("dma not acknowledged");
  property p_addr;
    @(posedge clk) disable iff (!rstn)
      start && !sys_dma |=> drive_reg_addr == $past(sys_addr[2:0]);
  endproperty
  a_addr: assert property (p_addr) else $error("register address wrong");
  property p_reset_out;
    @(posedge clk) disable iff (!rstn)
      sys_drive_reset && state == ADH_IDLE |=> !drive_reset_n;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("drive reset not asserted");

endmodule
`default_nettype wire

/* File: test/adh_drive_model.sv */
// adh_drive_model: behavioural disk drive on the far side of the host port
// assumes the bench sets the read word, the ready stall and the dma wish
`timescale 1ns/1ps
`default_nettype none
module adh_drive_model (
  // host pins
  input  wire logic        clk,
  input  wire logic [15:0] host_data,
  input  wire logic        host_oe,
  input  wire logic [2:0]  reg_addr,
  input  wire logic        wr_n,
  input  wire logic        rd_n,
  input  wire logic        cs1_n,
  input  wire logic        cs3_n,
  input  wire logic        ack_n,
  // scenario control
  input  wire logic [15:0] rd_word,
  input  wire logic [7:0]  stall,
  input  wire logic        want_dma,
  // drive pins
  output logic [15:0]      data_in,
  output logic             ready,
  output logic             dma_req,
  // last strobe seen
  output logic [15:0]      last_wdata,
  output logic [5:0]       last_pins
);
  logic [15:0] last;
  logic [7:0]  cnt;
  // undriven bus shows the inverse of its last level
  assign data_in = host_oe ? host_data : (!rd_n ? rd_word : ~last);
  assign ready   = (rd_n && wr_n) || (cnt >= stall);
  assign dma_req = want_dma;
  always_ff @(posedge clk) begin
    last <= data_in;
    cnt  <= (rd_n && wr_n) ? 8'h00 : (cnt == 8'hFF ? cnt : cnt + 8'h01);
  end
  always @(posedge wr_n) last_wdata <= data_in;
  always @(posedge wr_n or posedge rd_n) last_pins <= {cs1_n, cs3_n, ack_n, reg_addr};
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// testbench: directed scenarios for the disk host port
// assumes the behavioural drive model and a shortened drive reset
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, rstn = 0, sys_req = 0, sys_write = 0, sys_dma = 0, sys_drive_reset = 0;
  logic [9:0] sys_addr = 10'h000;
  logic [15:0] sys_wdata = 16'h0000, rd_word = 16'h0000, drive_data_in, drive_data_out, sys_rdata, last_wdata;
  logic [2:0] sys_mode = 3'h0, drive_reg_addr;
  logic [7:0] stall = 8'h00;
  logic [5:0] last_pins;
  logic want_dma = 0, drive_interrupt = 0, cable_type_detect_n = 1, drive_ready_wait, drive_dma_request;
  logic sys_ack, sys_irq_event, sys_cable_80, sys_udma_fast_ok, sys_dma_pending, sys_reset_busy;
  logic drive_data_oe, drive_write_strobe_n, drive_read_strobe_n, drive_dma_ack_n;
  logic cmd_block_select_n, ctrl_block_select_n, drive_reset_n;
  int err_count = 0, compares = 0, n0, n1;
  always #2.5 clk = ~clk;
  adh_host_port #(.RESET_CYC(20)) adh_host_port_i (.clk, .rstn, .sys_req, .sys_write, .sys_dma, .sys_addr,
    .sys_wdata, .sys_drive_reset, .sys_mode, .sys_ack, .sys_rdata, .sys_irq_event, .sys_cable_80,
    .sys_udma_fast_ok, .sys_dma_pending, .sys_reset_busy, .drive_data_in, .drive_data_out, .drive_data_oe,
    .drive_reg_addr, .drive_write_strobe_n, .drive_read_strobe_n, .drive_dma_request, .drive_dma_ack_n,
    .cmd_block_select_n, .ctrl_block_select_n, .drive_ready_wait, .drive_reset_n, .drive_interrupt,
    .cable_type_detect_n);
  adh_drive_model adh_drive_model_i (.clk, .host_data(drive_data_out), .host_oe(drive_data_oe),
    .reg_addr(drive_reg_addr), .wr_n(drive_write_strobe_n), .rd_n(drive_read_strobe_n),
    .cs1_n(cmd_block_select_n), .cs3_n(ctrl_block_select_n), .ack_n(drive_dma_ack_n), .rd_word,
    .stall, .want_dma, .data_in(drive_data_in), .ready(drive_ready_wait), .dma_req(drive_dma_request),
    .last_wdata, .last_pins);
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 300 && sys_reset_busy !== 1'b0; k++) @(negedge clk);
    if (k >= 300) begin
      chk("busy timeout", 16'h0, 16'h1);
      end_sim();
    end
  endtask
  task automatic cyc(input logic w, input logic d, input logic [9:0] a, input logic [15:0] wd, output int n);
    n = 0;
    @(negedge clk);
    sys_write = w; sys_dma = d; sys_addr = a; sys_wdata = wd; sys_req = 1'b1;
    while (sys_ack !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    sys_req = 1'b0;
    if (n >= 300) begin
      chk("ack timeout", 16'h0, 16'h1);
      end_sim();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_pio();
    cyc(1, 0, 10'h1F3, 16'hA55A, n0);
    chk("wdata", 16'hA55A, last_wdata);
    chk("pins cmd", 16'(6'b011_011), 16'(last_pins));
    cyc(1, 0, 10'h1FF, 16'h0001, n0);
    chk("pins cmd top", 16'(6'b011_111), 16'(last_pins));
    rd_word = 16'h3C96;
    stall = 8'h1E;
    cyc(0, 0, 10'h3F6, 16'h0000, n1);
    chk("rdata", 16'h3C96, sys_rdata);
    chk("pins ctrl", 16'(6'b101_110), 16'(last_pins));
    chk("stretched", 16'h1, 16'(n1 > n0));
    chk("stretch cycles", 16'h0010, 16'(n1 - n0));
    stall = 8'h00;
    cyc(1, 0, 10'h1EF, 16'h0002, n0);
    chk("pins none low", 16'(6'b111_111), 16'(last_pins));
    cyc(0, 0, 10'h3EF, 16'h0000, n0);
    chk("pins none ctrl", 16'(6'b111_111), 16'(last_pins));
  endtask
  task automatic t_dma();
    int k;
    want_dma = 0;
    @(negedge clk);
    sys_dma = 1; sys_write = 1; sys_wdata = 16'h5AA5; sys_req = 1;
    for (k = 0; k < 40; k++) begin
      @(negedge clk);
      chk("ack_n idle", 16'h1, 16'(drive_dma_ack_n));
    end
    sys_req = 0;
    want_dma = 1;
    @(negedge clk);
    @(negedge clk);
    chk("pending", 16'h1, 16'(sys_dma_pending));
    cyc(1, 1, 10'h1F0, 16'h5AA5, n0);
    chk("dma wdata", 16'h5AA5, last_wdata);
    chk("dma pins", 16'(6'b110_000), 16'(last_pins));
    want_dma = 0;
  endtask
  task automatic t_status();
    int k, c;
    c = 0;
    drive_interrupt = 1;
    for (k = 0; k < 8; k++) begin
      @(negedge clk);
      c += (sys_irq_event === 1'b1);
    end
    drive_interrupt = 0;
    chk("irq events", 16'h1, 16'(c));
    sys_mode = 3'h4;
    cable_type_detect_n = 1;
    repeat (3) @(negedge clk);
    chk("cable40", 16'h0, 16'({sys_cable_80, sys_udma_fast_ok}));
    sys_mode = 3'h3;
    repeat (3) @(negedge clk);
    chk("mode3 on 40", 16'h1, 16'(sys_udma_fast_ok));
    sys_mode = 3'h6;
    cable_type_detect_n = 0;
    repeat (3) @(negedge clk);
    chk("cable80", 16'h3, 16'({sys_cable_80, sys_udma_fast_ok}));
  endtask
  task automatic t_reset();
    @(negedge clk);
    sys_drive_reset = 1;
    repeat (3) @(negedge clk);
    sys_drive_reset = 0;
    chk("drive reset", 16'h0, 16'(drive_reset_n));
    wait_idle();
    chk("drive reset end", 16'h1, 16'(drive_reset_n));
  endtask
  initial begin
    repeat (6) @(negedge clk);
    chk("reset hold", 16'h0, 16'(drive_reset_n));
    rstn = 1;
    wait_idle();
    t_pio();
    t_dma();
    t_status();
    t_reset();
    end_sim();
  end
endmodule
`default_nettype wire
